/* File: rtl/pwm_out_pkg.sv */
package pwm_out_pkg;

    // Register bus widths.
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;

    // Register addresses as printed.
    localparam logic [15:0] T3_OUT_ADDR  = 16'h7407;
    localparam logic [15:0] T4_OUT_ADDR  = 16'h7408;
    localparam logic [15:0] T3_DEAD_ADDR = 16'h7460;
    localparam logic [15:0] T4_DEAD_ADDR = 16'h7461;

    // Reset values and writable-bit masks; reserved bits read zero.
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] OUT_MASK  = 16'hc7ff;
    localparam logic [15:0] DEAD_MASK = 16'h707f;

    // Output control field positions.
    localparam int DUTY_BIT    = 15;
    localparam int POL_BIT     = 14;
    localparam int WAVE_LSB    = 8;
    localparam int SYNC_LSB    = 6;
    localparam int MODE_LSB    = 0;

    // Dead-time control field positions.
    localparam int DEAD_EN_LSB = 12;
    localparam int PERIOD_LSB  = 0;
    localparam int PERIOD_W    = 7;

    // Synchronisation source codes.
    localparam logic [1:0] SYNC_NONE = 2'h0;
    localparam logic [1:0] SYNC_POS  = 2'h1;
    localparam logic [1:0] SYNC_CMP2 = 2'h2;
    localparam logic [1:0] SYNC_CMP3 = 2'h3;

    // Pair mode codes.
    localparam logic [1:0] MODE_COMP_A  = 2'h0;
    localparam logic [1:0] MODE_LOWER   = 2'h1;
    localparam logic [1:0] MODE_UPPER   = 2'h2;
    localparam logic [1:0] MODE_COMP_B  = 2'h3;

    // The dead-time tick is the system clock divided by four.
    localparam int         TICK_DIV  = 4;
    localparam logic [1:0] TICK_LAST = 2'(TICK_DIV - 1);
    localparam logic [1:0] TICK_RESET = 2'h0;

endpackage

/* File: rtl/phase_pair.sv */
`timescale 1ns/1ps
// One upper/lower output pair with its own dead-time counter.
module phase_pair (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       tick,      // Quarter-rate pulse, one cycle long.
    input  wire logic       pwm,       // Selected duty waveform for this phase.
    input  wire logic       wave_sel,  // High for PWM, low for static levels.
    input  wire logic [1:0] mode,      // Pair mode, 0 to 3.
    input  wire logic       polarity,  // High for active-high outputs.
    input  wire logic       dead_en,   // Dead-time enable for this phase.
    input  wire logic [6:0] period,    // Dead time in quarter-rate ticks.
    output logic            upper,
    output logic            lower
);

    logic       prev_pwm;        // Last seen waveform, for edge detection.
    logic [6:0] dead_cnt;        // Remaining dead-time ticks.
    logic       next_prev_pwm;
    logic [6:0] next_dead_cnt;
    logic       next_upper;
    logic       next_lower;
    logic       comp;            // Pair runs complementary PWM.
    logic       dead_active;     // Dead time is inserted on this pair.
    logic       changed;         // Waveform toggled this cycle.
    logic       settled;         // Dead gap has elapsed.
    logic       up_on;           // Upper output asserted, active-high form.
    logic       lo_on;           // Lower output asserted, active-high form.

    // Dead-time counter and the mapping from mode to output levels.
    always_comb begin
        comp = wave_sel && (mode == pwm_out_pkg::MODE_COMP_A ||
                            mode == pwm_out_pkg::MODE_COMP_B);
        // Modes 1 and 2 fall out of comp, so they never see a gap.
        dead_active = comp && dead_en;
        changed = (pwm != prev_pwm);
        next_prev_pwm = pwm;
        if (!dead_active) begin
            next_dead_cnt = 7'h00;
        end else if (changed) begin
            // Every toggle restarts the gap from the programmed period.
            next_dead_cnt = period;
        end else if (tick && dead_cnt != 7'h00) begin
            next_dead_cnt = dead_cnt - 7'h01;
        end else begin
            next_dead_cnt = dead_cnt;
        end
        settled = !dead_active || (dead_cnt == 7'h00 && !changed);
        if (wave_sel) begin
            // PWM tables, shared by all six pairs.
            unique case (mode)
                pwm_out_pkg::MODE_COMP_A: begin
                    up_on = ~pwm;
                    lo_on = pwm;
                end
                pwm_out_pkg::MODE_LOWER: begin
                    up_on = 1'b0;
                    lo_on = pwm;
                end
                pwm_out_pkg::MODE_UPPER: begin
                    up_on = pwm;
                    lo_on = 1'b0;
                end
                pwm_out_pkg::MODE_COMP_B: begin
                    up_on = pwm;
                    lo_on = ~pwm;
                end
            endcase
        end else begin
            // Static levels ignore the waveform and counter entirely.
            up_on = mode[1];
            lo_on = mode[0];
        end
        // The gap holds back only the turn-on edge; turn-off is immediate,
        // so in PWM modes the two switches are never on together.
        next_upper = up_on && settled;
        next_lower = lo_on && settled;
        if (!polarity) begin
            // Active-low polarity inverts both tables.
            next_upper = ~next_upper;
            next_lower = ~next_lower;
        end
    end

    // Register the pair state; outputs come straight from flops.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_pwm <= 1'b0;
            dead_cnt <= 7'h00;
            upper    <= 1'b0;
            lower    <= 1'b0;
        end else begin
            prev_pwm <= next_prev_pwm;
            dead_cnt <= next_dead_cnt;
            upper    <= next_upper;
            lower    <= next_lower;
        end
    end

endmodule

/* File: rtl/pwm_output_stage.sv */
`timescale 1ns/1ps
// Output stage for two three-phase timers: registers, sync and six pairs.
// Index of a pair is timer * 3 + phase, phase 0 = U, 1 = V, 2 = W.
module pwm_output_stage (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] addr,         // Register address.
    input  wire logic [15:0] wr_data,      // Write data.
    input  wire logic        wr_en,        // Write strobe, one cycle.
    input  wire logic        rd_en,        // Read strobe, one cycle.
    output logic      [15:0] rd_data,      // Read data, the cycle after rd_en.
    input  wire logic [1:0]  pwm_first,    // Duty wave from first compare, per timer.
    input  wire logic [5:0]  pwm_phase,    // Duty wave per phase compare.
    input  wire logic        pos_change,   // Position-detect value changed, pulse.
    input  wire logic [1:0]  cmp2_match,   // Second compare match, per timer.
    input  wire logic [1:0]  cmp3_match,   // Third compare match, per timer.
    output logic      [5:0]  upper,        // Upper gate outputs.
    output logic      [5:0]  lower         // Lower gate outputs.
);

    logic [15:0] out_shadow [2];     // Output control as written by software.
    logic [15:0] out_active [2];     // Output control driving the pairs.
    logic [15:0] dead_ctrl  [2];     // Dead-time control.
    logic [15:0] next_out_shadow [2];
    logic [15:0] next_out_active [2];
    logic [15:0] next_dead_ctrl  [2];
    logic [1:0]  tick_cnt;           // Divider for the quarter-rate tick.
    logic        tick;               // Quarter-rate enable pulse.
    logic [1:0]  next_tick_cnt;
    logic        next_tick;
    logic [15:0] next_rd_data;
    logic [15:0] out_addr  [2];      // Per-timer address of output control.
    logic [15:0] dead_addr [2];      // Per-timer address of dead-time control.
    logic [5:0]  duty_wave;          // Duty waveform chosen for each pair.

    assign out_addr[0]  = pwm_out_pkg::T3_OUT_ADDR;
    assign out_addr[1]  = pwm_out_pkg::T4_OUT_ADDR;
    assign dead_addr[0] = pwm_out_pkg::T3_DEAD_ADDR;
    assign dead_addr[1] = pwm_out_pkg::T4_DEAD_ADDR;

    // Quarter-rate tick divider for dead-time counting.
    always_comb begin
        next_tick_cnt = tick_cnt + 2'h1;
        next_tick = (tick_cnt == pwm_out_pkg::TICK_LAST);
    end

    // Register the divider.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tick_cnt <= pwm_out_pkg::TICK_RESET;
            tick     <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            tick     <= next_tick;
        end
    end

    // Read mux; unmapped addresses read as zero.
    always_comb begin
        next_rd_data = 16'h0000;
        if (rd_en) begin
            for (int t = 0; t < 2; t++) begin
                if (addr == out_addr[t]) begin
                    next_rd_data = out_shadow[t];
                end
                if (addr == dead_addr[t]) begin
                    next_rd_data = dead_ctrl[t];
                end
            end
        end
    end

    // Read data stands for one cycle only.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= 16'h0000;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    for (genvar t = 0; t < 2; t++) begin : g_timer
        logic [1:0] sync_sel;    // Sync source, effective immediately.
        logic       apply;       // Held settings move to the active copy.

        // Register writes and synchronised application of output settings.
        always_comb begin
            next_out_shadow[t] = out_shadow[t];
            next_dead_ctrl[t]  = dead_ctrl[t];
            if (wr_en && addr == out_addr[t]) begin
                next_out_shadow[t] = wr_data & pwm_out_pkg::OUT_MASK;
            end
            if (wr_en && addr == dead_addr[t]) begin
                next_dead_ctrl[t] = wr_data & pwm_out_pkg::DEAD_MASK;
            end
            sync_sel = next_out_shadow[t][pwm_out_pkg::SYNC_LSB +: 2];
            unique case (sync_sel)
                pwm_out_pkg::SYNC_NONE: apply = 1'b1;
                pwm_out_pkg::SYNC_POS:  apply = pos_change;
                pwm_out_pkg::SYNC_CMP2: apply = cmp2_match[t];
                pwm_out_pkg::SYNC_CMP3: apply = cmp3_match[t];
            endcase
            // A write landing with the event is applied by that event,
            // since the active copy is loaded from the new shadow value.
            next_out_active[t] = apply ? next_out_shadow[t] : out_active[t];
        end

        // Register the timer's control words.
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                out_shadow[t] <= pwm_out_pkg::REG_RESET;
                out_active[t] <= pwm_out_pkg::REG_RESET;
                dead_ctrl[t]  <= pwm_out_pkg::REG_RESET;
            end else begin
                out_shadow[t] <= next_out_shadow[t];
                out_active[t] <= next_out_active[t];
                dead_ctrl[t]  <= next_dead_ctrl[t];
            end
        end

        for (genvar p = 0; p < 3; p++) begin : g_phase
            // Duty select is not held back by sync; it only picks a source.
            assign duty_wave[t*3+p] = out_shadow[t][pwm_out_pkg::DUTY_BIT]
                                    ? pwm_phase[t*3+p]
                                    : pwm_first[t];

            phase_pair u_pair (
                .clk      (clk),
                .rst_n    (rst_n),
                .tick     (tick),
                .pwm      (duty_wave[t*3+p]),
                .wave_sel (out_active[t][pwm_out_pkg::WAVE_LSB + p]),
                .mode     (out_active[t][pwm_out_pkg::MODE_LSB + 2*p +: 2]),
                .polarity (out_active[t][pwm_out_pkg::POL_BIT]),
                .dead_en  (dead_ctrl[t][pwm_out_pkg::DEAD_EN_LSB + p]),
                .period   (dead_ctrl[t][pwm_out_pkg::PERIOD_LSB +: pwm_out_pkg::PERIOD_W]),
                .upper    (upper[t*3+p]),
                .lower    (lower[t*3+p])
            );
        end
    end

    // Software is expected to set a period and enables before running
    // modes 0 or 3; with dead time off the pair still switches cleanly
    // but both transistors may briefly overlap in the bridge.

endmodule

/* File: sim/pwm_output_stage_checker.sv */
`timescale 1ns/1ps
// Port-level checks of the register bus and of the state left by reset.
module pwm_output_stage_checker (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [15:0] addr,
    input wire logic [15:0] wr_data,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [15:0] rd_data,
    input wire logic [5:0]  upper,
    input wire logic [5:0]  lower
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Decode of the output control and dead-time control places.
    wire logic out_hit = addr == pwm_out_pkg::T3_OUT_ADDR || addr == pwm_out_pkg::T4_OUT_ADDR;
    wire logic dead_hit = addr == pwm_out_pkg::T3_DEAD_ADDR || addr == pwm_out_pkg::T4_DEAD_ADDR;
    // A write followed at once by a read of the same place.
    sequence wr_then_rd(logic hit);
        wr_en && hit ##1 rd_en && hit && $stable(addr);
    endsequence
    AST_IDLE_ZERO: assert property (!rd_en |=> rd_data == 16'h0)
        else $error("read data not zero outside a read");
    AST_UNMAPPED: assert property (rd_en && !out_hit && !dead_hit |=> rd_data == 16'h0)
        else $error("unmapped read not zero");
    AST_OUT_RSVD: assert property (rd_en && out_hit |=>
        (rd_data & ~pwm_out_pkg::OUT_MASK) == 16'h0)
        else $error("output control reserved bits set");
    AST_DEAD_RSVD: assert property (rd_en && dead_hit |=>
        (rd_data & ~pwm_out_pkg::DEAD_MASK) == 16'h0)
        else $error("dead-time control reserved bits set");
    AST_OUT_BACK: assert property (wr_then_rd(out_hit) |=>
        rd_data == ($past(wr_data, 2) & pwm_out_pkg::OUT_MASK)) else $error("output control lost");
    AST_DEAD_BACK: assert property (wr_then_rd(dead_hit) |=>
        rd_data == ($past(wr_data, 2) & pwm_out_pkg::DEAD_MASK)) else $error("dead control lost");
    AST_RESET_OUT: assert property ($rose(rst_n) |=>
        (upper == 6'h3f && lower == 6'h3f) [*2])
        else $error("outputs not high after reset");
    AST_HOLD_STATIC: assert property ($rose(rst_n) ##0 !wr_en [*4] |=> lower == 6'h3f)
        else $error("static lower outputs moved without a write");
endmodule
bind pwm_output_stage pwm_output_stage_checker u_pwm_output_stage_checker (.clk, .rst_n,
    .addr, .wr_data, .wr_en, .rd_en, .rd_data, .upper, .lower);

/* File: sim/gate_drive_model.sv */
`timescale 1ns/1ps
// Gate drivers of one inverter bridge; counts cycles where a leg conducts fully.
module gate_drive_model (
    input  wire logic       clk,
    input  wire logic       pol,    // High when the gates are driven active high.
    input  wire logic [2:0] upper,
    input  wire logic [2:0] lower,
    output int              shoots  // Cycles with both switches of a leg on.
);
    initial shoots = 0;
    // Both switches on shorts the supply, so the real bridge would fail here.
    always @(posedge clk) begin
        if (|(~(upper ^ {3{pol}}) & ~(lower ^ {3{pol}}))) begin
            shoots <= shoots + 1;
        end
    end
endmodule

/* File: sim/pwm_output_stage_tb_top.sv */
`timescale 1ns/1ps
// Self-checking bench for the two-timer output stage.
module pwm_output_stage_tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] addr = 16'h0;
    logic [15:0] wr_data = 16'h0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic [15:0] rd_data;
    logic [1:0]  pwm_first = 2'h0;
    logic [5:0]  pwm_phase = 6'h0;
    logic        pos_change = 1'b0;
    logic [1:0]  cmp2_match = 2'h0;
    logic [1:0]  cmp3_match = 2'h0;
    logic [5:0]  upper;
    logic [5:0]  lower;
    logic [15:0] a3 = 16'h0;  // Active settings expected for each timer.
    logic [15:0] a4 = 16'h0;
    logic [15:0] am [5] = '{16'h7407, 16'h7408, 16'h7460, 16'h7461, 16'h7409};
    logic [15:0] mk [5] = '{16'hc7ff, 16'hc7ff, 16'h707f, 16'h707f, 16'h0000};
    int          fails = 0;
    int          checked = 0;
    int          cyc = 0;
    int          k, p, n, g, h, shoots;
    always #12.5 clk = ~clk;
    pwm_output_stage u_pwm_output_stage (.clk, .rst_n, .addr, .wr_data, .wr_en, .rd_en,
        .rd_data, .pwm_first, .pwm_phase, .pos_change, .cmp2_match, .cmp3_match, .upper, .lower);
    gate_drive_model u_gate_drive_model (.clk, .pol(a3[14]), .upper(upper[2:0]),
        .lower(lower[2:0]), .shoots);
    // A hang is cut short well beyond the few hundred cycles the run needs.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            results();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    // Strobes drop here, so a write or read task never lowers its own strobe.
    task automatic step(input int c);
        {wr_en, rd_en} <= 2'b00;
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        addr <= a;
        wr_data <= v;
        {wr_en, rd_en} <= 2'b10;
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        addr <= a;
        {wr_en, rd_en} <= 2'b01;
        @(posedge clk);
        #1;
        chk(rd_data, e);
    endtask
    // One-cycle pulse on the sync events of both timers, then one idle cycle.
    task automatic ev(input logic [2:0] e);
        {pos_change, cmp2_match, cmp3_match} <= {e[2], {2{e[1]}}, {2{e[0]}}};
        step(1);
        {pos_change, cmp2_match, cmp3_match} <= 5'h00;
        step(1);
    endtask
    // Expected upper/lower of one pair in active-high form, then polarity applied.
    function automatic logic [1:0] pe(logic pol, logic wave, logic w, logic [1:0] m);
        logic u, l;
        u = wave ? (m == 2'h1 ? 1'b0 : (m == 2'h0 ? ~w : w)) : m[1];
        l = wave ? (m == 2'h2 ? 1'b0 : (m == 2'h3 ? ~w : w)) : m[0];
        return {u, l} ^ {2{~pol}};
    endfunction
    task automatic outs;
        logic [15:0] c;
        for (int i = 0; i < 6; i++) begin
            c = i < 3 ? a3 : a4;
            chk({14'h0, upper[i], lower[i]}, {14'h0, pe(c[14], c[8 + i % 3],
                c[15] ? pwm_phase[i] : pwm_first[i / 3], c[2 * (i % 3) +: 2])});
        end
    endtask
    task automatic results;
        $display("checks %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h636e));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        step(2);
        outs();
        for (int i = 0; i < 5; i++) begin
            rd(am[i], 16'h0);
        end
        repeat (24) begin
            k = $urandom_range(4);
            wr(am[k], 16'($urandom));
            rd(am[k], wr_data & mk[k]);
        end
        wr(16'h7460, 16'h0);
        wr(16'h7461, 16'h0);
        $display("test registers done");
        // Every polarity, waveform, duty source and mode, phases offset by one mode.
        for (int c = 0; c < 32; c++) begin
            k = c % 4;
            a3 = {c[4], c[3], 3'h0, {3{c[2]}}, 2'h0, 2'(k + 2), 2'(k + 1), 2'(k)};
            a4 = a3 ^ 16'h003f;
            wr(16'h7407, a3);
            wr(16'h7408, a4);
            repeat (2) begin
                pwm_first <= 2'($urandom);
                pwm_phase <= 6'($urandom);
                step(2);
                outs();
            end
        end
        $display("test output tables done");
        // New settings wait for the chosen event and ignore one of the other two.
        // Both timers take part, so the second timer's match inputs are exercised too.
        for (int s = 1; s < 4; s++) begin
            a3 = 16'h4000;
            a4 = 16'h4000;
            wr(16'h7407, a3);
            wr(16'h7408, a4);
            wr(16'h7407, {8'h40, 2'(s), 6'h3f});
            wr(16'h7408, {8'h40, 2'(s), 6'h3f});
            ev(3'h4 >> (s % 3));
            step(1);
            outs();
            ev(3'h4 >> (s - 1));
            a3 = {8'h40, 2'(s), 6'h3f};
            a4 = a3;
            outs();
        end
        $display("test sync done");
        // U mode 0 and W mode 1 with dead time on, V mode 3 with it off.
        p = $urandom_range(20, 1);
        a3 = 16'h471c;
        pwm_first <= 2'h0;
        wr(16'h7407, a3);
        wr(16'h7460, 16'h5000 | 16'(p));
        step(4 * p + 12);
        n = shoots;
        g = 0;
        h = 0;
        pwm_first <= 2'h1;
        repeat (4 * p + 12) begin
            step(1);
            g += int'(!upper[0] && !lower[0]);
            h += int'(!upper[1] && !lower[1]) + int'(!lower[2]);
        end
        // The gap counts p ticks of a free divider, so its phase moves it
        // anywhere from 4p-2 to 4p+1 cycles.
        chk({15'h0, g >= 4 * p - 2 && g <= 4 * p + 1}, 16'h1);
        chk(16'(h), 16'h0);
        chk({14'h0, upper[0], lower[0]}, 16'h1);
        chk(16'(shoots - n), 16'h0);
        $display("test dead time done");
        results();
    end
endmodule
